// *** common/ica_pkg.sv ***
package ica_pkg;

	localparam int ICA_NCH = 6;
	localparam int ICA_DW = 16;
	localparam int ICA_RW = 3;
	localparam int ICA_NRANGE = 8;
	localparam int ICA_GROUP = 3;
	localparam int ICA_REFW = 32;

	// Holding register numbers
	localparam logic [15:0] ICA_REG_UNLOCK = 16'h0015;
	localparam logic [15:0] ICA_REG_ZERO = 16'h0016;
	localparam logic [15:0] ICA_REG_SPAN = 16'h0017;

	// Unlock key and relock value
	localparam logic [15:0] ICA_KEY = 16'h5E2A;
	localparam logic [15:0] ICA_RELOCK = 16'h0000;
	localparam logic [15:0] ICA_KEY_RST = 16'h0000;
	localparam logic [15:0] ICA_UNMAPPED = 16'h0000;

	// Coefficient reset values
	localparam logic [15:0] ICA_ZERO_RST = 16'h0000;
	localparam logic [15:0] ICA_FULL_SCALE_RST = 16'hFFFF;

	// Current-variant range codes
	localparam logic [2:0] ICA_CUR_0_20 = 3'h0;
	localparam logic [2:0] ICA_CUR_4_20 = 3'h1;
	localparam logic [2:0] ICA_CUR_0_11 = 3'h2;
	localparam logic [2:0] ICA_CUR_0_1 = 3'h3;

	// Endpoint references: nanoamps for current, microvolts for voltage
	function automatic logic signed [31:0] ica_ref(input logic cur, input logic [2:0] rng,
		input logic full_scale);
		logic signed [31:0] mag;
		mag = 32'sh0000_0000;
		if (cur) begin
			case (rng)
				ICA_CUR_0_11: mag = full_scale ? 32'sh00AA_70D0 : 32'sh000F_4240;
				ICA_CUR_0_1: mag = full_scale ? 32'sh000F_4240 : 32'sh0003_D090;
				default: mag = full_scale ? 32'sh0131_2D00 : 32'sh000F_4240;
			endcase
			return mag;
		end
		case (rng)
			3'h0: mag = 32'sh0098_9680;
			3'h1: mag = 32'sh004C_4B40;
			3'h2: mag = 32'sh0026_25A0;
			3'h3: mag = 32'sh0013_12D0;
			3'h4: mag = 32'sh0009_8968;
			3'h5: mag = 32'sh0004_C4B4;
			3'h6: mag = 32'sh0002_625A;
			default: mag = 32'sh0001_3132;
		endcase
		return full_scale ? mag : -mag;
	endfunction

endpackage

// *** core/ica_cal_slot.sv ***
`timescale 1ns/1ps
`default_nettype none

module ica_cal_slot #(
	parameter int DW = ica_pkg::ICA_DW,
	parameter int RW = ica_pkg::ICA_RW,
	parameter int NR = ica_pkg::ICA_NRANGE
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic wr_zero,
	input wire logic wr_span,
	input wire logic [RW-1:0] wr_range,
	input wire logic [DW-1:0] sample,
	input wire logic [RW-1:0] rd_range,
	output logic [DW-1:0] rd_zero,
	output logic [DW-1:0] rd_full_scale
);

	logic [DW-1:0] zero_mem [NR];
	logic [DW-1:0] full_scale_mem [NR];
	logic [DW-1:0] next_zero_mem [NR];
	logic [DW-1:0] next_full_scale_mem [NR];

	// Replace the endpoint of the selected range only
	always_comb begin
		next_zero_mem = zero_mem;
		next_full_scale_mem = full_scale_mem;
		if (ce && wr_zero) begin
			next_zero_mem[wr_range] = sample;
		end
		if (ce && wr_span) begin
			next_full_scale_mem[wr_range] = sample;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int r = 0; r < NR; r++) begin
				zero_mem[r] <= ica_pkg::ICA_ZERO_RST;
				full_scale_mem[r] <= ica_pkg::ICA_FULL_SCALE_RST;
			end
		end else begin
			zero_mem <= next_zero_mem;
			full_scale_mem <= next_full_scale_mem;
		end
	end

	// Unregistered read; the top registers it
	assign rd_zero = zero_mem[rd_range];
	assign rd_full_scale = full_scale_mem[rd_range];

endmodule

`default_nettype wire

// *** core/ica_top.sv ***
// Contract
// - Calibration registers stay locked until key 5E2A is written to unlock register.
// - Writing zero to unlock register (holding register 21) relocks calibration.
// - Zero command: 16-bit write, bit at channel number set, one channel.
// - Accepted command replaces that channel's zero or span coefficient for its selected range at once, no reset.
// - Span command: 16-bit write with only target channel bit set.
// - Current variant: 4-20mA shares the 0-20mA coefficients.
// - Current references: 1.0/20.0, 1.0/11.17, 0.25/1.00 mA.
// - Voltage references: negative and positive range limit, 10000 to 78.13 mV.
// - Channels 0-2 share one range, channels 3-5 another.
`timescale 1ns/1ps
`default_nettype none

module ica_top #(
	parameter int NCH = ica_pkg::ICA_NCH,
	parameter int DW = ica_pkg::ICA_DW
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic hr_wr,
	input wire logic hr_rd,
	input wire logic [15:0] hr_addr,
	input wire logic [15:0] hr_wdata,
	output logic [15:0] hr_rdata,
	output logic hr_rvalid,
	input wire logic current_variant,
	input wire logic [2:0] group0_range,
	input wire logic [2:0] group1_range,
	input wire logic [NCH*DW-1:0] adc_sample,
	input wire logic [2:0] rb_chan,
	input wire logic [2:0] rb_range,
	output logic [DW-1:0] rb_zero_coef,
	output logic [DW-1:0] rb_full_scale_coef,
	output logic cal_unlocked,
	output logic cal_update,
	output logic cal_span,
	output logic [2:0] cal_chan,
	output logic [2:0] cal_range,
	output logic signed [31:0] zero_endpoint_signal,
	output logic signed [31:0] full_scale_endpoint_signal
);

	// Returns {valid, channel}; valid only for exactly one bit among live channels
	// one-hot decode
	function automatic logic [3:0] chan_of(input logic [15:0] v);
		logic [3:0] res;
		int cnt;
		int pos;
		res = 4'h0;
		cnt = 0;
		pos = 0;
		for (int b = 0; b < 16; b++) begin
			if (v[b]) begin
				cnt++;
				pos = b;
			end
		end
		// Full position kept so bits 8 and up cannot alias onto a live channel
		res[2:0] = 3'(pos);
		res[3] = (cnt == 1) && (pos < NCH);
		return res;
	endfunction

	// Coefficient slot that a channel range selection maps to
	function automatic logic [2:0] eff_range(input logic cur, input logic [2:0] rng);
		return (cur && rng == ica_pkg::ICA_CUR_4_20) ? ica_pkg::ICA_CUR_0_20 : rng;
	endfunction

	logic [15:0] key_reg, next_key_reg;
	logic [3:0] dec;
	logic [2:0] grp_range, slot;
	logic is_zero, is_span, accept;
	logic [DW-1:0] slot_zero [NCH];
	logic [DW-1:0] slot_full_scale [NCH];
	logic [15:0] next_rdata;
	logic next_rvalid, next_unlocked, next_update, next_span;
	logic [2:0] next_chan, next_range;
	logic signed [31:0] next_zero_ref, next_full_scale_ref;
	logic [DW-1:0] next_rb_zero, next_rb_full_scale;

	// Command decode
	always_comb begin
		is_zero = hr_wr && hr_addr == ica_pkg::ICA_REG_ZERO;
		is_span = hr_wr && hr_addr == ica_pkg::ICA_REG_SPAN;
		dec = chan_of(hr_wdata);
		// lower three channels use group 0 range
		grp_range = (dec[2:0] < 3'(ica_pkg::ICA_GROUP)) ? group0_range : group1_range;
		slot = eff_range(current_variant, grp_range);
		// locked commands fall through; malformed value dropped
		accept = ce && (is_zero || is_span) && cal_unlocked && dec[3];
	end

	// Key register and all registered outputs
	always_comb begin
		next_key_reg = key_reg;
		// key stored, unlocking when it matches
		if (ce && hr_wr && hr_addr == ica_pkg::ICA_REG_UNLOCK) begin
			// zero (or any value other than the key) relocks
			next_key_reg = hr_wdata;
		end
		next_unlocked = next_key_reg == ica_pkg::ICA_KEY;
		// Zero and span read back as zero: they are write-only strobes
		next_rdata = (hr_addr == ica_pkg::ICA_REG_UNLOCK) ? key_reg : ica_pkg::ICA_UNMAPPED;
		next_rvalid = hr_rd;
		next_update = accept;
		next_span = accept ? is_span : cal_span;
		next_chan = accept ? dec[2:0] : cal_chan;
		next_range = accept ? slot : cal_range;
		next_zero_ref = accept ? ica_pkg::ica_ref(current_variant, slot, 1'b0)
			: zero_endpoint_signal;
		next_full_scale_ref = accept ? ica_pkg::ica_ref(current_variant, slot, 1'b1)
			: full_scale_endpoint_signal;
		next_rb_zero = (rb_chan < 3'(NCH)) ? slot_zero[rb_chan] : slot_zero[0];
		next_rb_full_scale = (rb_chan < 3'(NCH)) ? slot_full_scale[rb_chan]
			: slot_full_scale[0];
	end

	// Everything freezes with ce low so a host stall cannot drop a pulse
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			key_reg <= ica_pkg::ICA_KEY_RST;
			hr_rdata <= 16'h0000;
			hr_rvalid <= 1'b0;
			cal_unlocked <= 1'b0;
			cal_update <= 1'b0;
			cal_span <= 1'b0;
			cal_chan <= 3'h0;
			cal_range <= 3'h0;
			zero_endpoint_signal <= 32'sh0000_0000;
			full_scale_endpoint_signal <= 32'sh0000_0000;
			rb_zero_coef <= ica_pkg::ICA_ZERO_RST;
			rb_full_scale_coef <= ica_pkg::ICA_FULL_SCALE_RST;
		end else if (ce) begin
			key_reg <= next_key_reg;
			hr_rdata <= next_rdata;
			hr_rvalid <= next_rvalid;
			cal_unlocked <= next_unlocked;
			cal_update <= next_update;
			cal_span <= next_span;
			cal_chan <= next_chan;
			cal_range <= next_range;
			zero_endpoint_signal <= next_zero_ref;
			full_scale_endpoint_signal <= next_full_scale_ref;
			rb_zero_coef <= next_rb_zero;
			rb_full_scale_coef <= next_rb_full_scale;
		end
	end

	// One coefficient store per channel
	for (genvar i = 0; i < NCH; i++) begin : g_slot
		// coefficients replaced on the accepting edge
		ica_cal_slot #(.DW(DW)) u_slot (
			.core_clk(core_clk),
			.nrst(nrst),
			.ce(ce),
			.wr_zero(accept && is_zero && dec[2:0] == 3'(i)),
			.wr_span(accept && is_span && dec[2:0] == 3'(i)),
			.wr_range(slot),
			.sample(adc_sample[i*DW +: DW]),
			.rd_range(eff_range(current_variant, rb_range)),
			.rd_zero(slot_zero[i]),
			.rd_full_scale(slot_full_scale[i])
		);
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_key_unlock;
		ce && hr_wr && hr_addr == 16'h0015 && hr_wdata == 16'h5E2A |=> cal_unlocked;
	endproperty
	a_key_unlock: assert property (p_key_unlock) else $error("key did not unlock");

	property p_relock;
		ce && hr_wr && hr_addr == 16'h0015 && hr_wdata == 16'h0000 |=> !cal_unlocked;
	endproperty
	a_relock: assert property (p_relock) else $error("zero did not relock");

	property p_zero_cmd;
		ce && hr_wr && hr_addr == 16'h0016 && cal_unlocked && hr_wdata == 16'h0020
			|=> cal_update && cal_chan == 3'h5 && !cal_span;
	endproperty
	a_zero_cmd: assert property (p_zero_cmd) else $error("zero command lost");

	property p_span_cmd;
		ce && hr_wr && hr_addr == 16'h0017 && cal_unlocked && hr_wdata == 16'h0001
			|=> cal_update && cal_chan == 3'h0 && cal_span;
	endproperty
	a_span_cmd: assert property (p_span_cmd) else $error("span command lost");

	sequence s_zero_ch0;
		ce && hr_wr && hr_addr == 16'h0016 && cal_unlocked && hr_wdata == 16'h0001;
	endsequence
	property p_immediate;
		s_zero_ch0 ##1 (ce && rb_chan == 3'h0 && rb_range == $past(group0_range)
			&& $stable(current_variant)) |=> rb_zero_coef == $past(adc_sample[DW-1:0], 2);
	endproperty
	a_immediate: assert property (p_immediate) else $error("coefficient not replaced");

	property p_sub_range;
		ce && hr_wr && hr_addr == 16'h0016 && cal_unlocked && hr_wdata == 16'h0001
			&& current_variant && group0_range == 3'h1 |=> cal_range == 3'h0;
	endproperty
	a_sub_range: assert property (p_sub_range) else $error("4-20 not folded");

	property p_ref_current;
		$rose(cal_update) && current_variant && cal_range == 3'h3
			|-> zero_endpoint_signal == 32'sh0003_D090
			&& full_scale_endpoint_signal == 32'sh000F_4240;
	endproperty
	a_ref_current: assert property (p_ref_current) else $error("bad current ref");

	property p_ref_volt;
		ce && accept && !current_variant && slot == 3'h0
			|=> zero_endpoint_signal == -32'sh0098_9680
			&& full_scale_endpoint_signal == 32'sh0098_9680;
	endproperty
	a_ref_volt: assert property (p_ref_volt) else $error("bad voltage ref");

	property p_group;
		ce && hr_wr && (hr_addr == 16'h0016 || hr_addr == 16'h0017) && cal_unlocked
			&& hr_wdata == 16'h0010 && !current_variant |=> cal_range == $past(group1_range);
	endproperty
	a_group: assert property (p_group) else $error("wrong group range");

	property p_locked;
		ce && hr_wr && (hr_addr == 16'h0016 || hr_addr == 16'h0017) && !cal_unlocked
			|=> !cal_update;
	endproperty
	a_locked: assert property (p_locked) else $error("locked write accepted");

	property p_malformed;
		ce && hr_wr && hr_addr == 16'h0016 && (hr_wdata & (hr_wdata - 16'h0001)) != 16'h0000
			|=> !cal_update;
	endproperty
	a_malformed: assert property (p_malformed) else $error("multi-bit accepted");

	c_unlock: cover property (!cal_unlocked ##1 cal_unlocked);
	c_zero: cover property (cal_update && !cal_span);
	c_span: cover property (cal_update && cal_span);
	c_relock: cover property (cal_unlocked ##1 !cal_unlocked);

endmodule

`default_nettype wire

// *** verif/ica_client_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Network client writing and reading holding registers
module ica_client_model (
	input wire logic core_clk,
	output logic hr_wr,
	output logic hr_rd,
	output logic [15:0] hr_addr,
	output logic [15:0] hr_wdata
);
	initial begin
		hr_wr = 1'b0;
		hr_rd = 1'b0;
		hr_addr = 16'h0000;
		hr_wdata = 16'h0000;
	end

	// whole words
	// Released lines show the inverse so stale data never matches
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		hr_wr <= 1'b1;
		hr_addr <= a;
		hr_wdata <= d;
		@(posedge core_clk);
		hr_wr <= 1'b0;
		hr_addr <= ~a;
		hr_wdata <= ~d;
	endtask

	task automatic rd(input logic [15:0] a);
		@(posedge core_clk);
		hr_rd <= 1'b1;
		hr_addr <= a;
		@(posedge core_clk);
		hr_rd <= 1'b0;
		hr_addr <= ~a;
	endtask
endmodule

`default_nettype wire

// *** verif/ica_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module ica_top_tb;
	logic core_clk, nrst, ce, hr_wr, hr_rd, hr_rvalid, cv, unl, upd, spn;
	logic [15:0] hr_addr, hr_wdata, hr_rdata, rb_zero, rb_full_scale;
	logic [2:0] g0, g1, rb_chan, rb_range, cch, crg;
	logic [95:0] adc;
	logic [31:0] zref, fref;
	logic [7:0] salt;
	int miscompares, compares, cycles;
	logic [15:0] bad [5] = '{16'h0000, 16'h0003, 16'h0040, 16'h8000, 16'h0100};
	// Settle wait after a new reference; scaled far down so the run stays short
	localparam int SETTLE_CYCLES = 4;

	ica_client_model i_ica_client_model (.core_clk(core_clk), .hr_wr(hr_wr), .hr_rd(hr_rd),
		.hr_addr(hr_addr), .hr_wdata(hr_wdata));

	ica_top i_ica_top (.core_clk(core_clk), .nrst(nrst), .ce(ce), .hr_wr(hr_wr),
		.hr_rd(hr_rd), .hr_addr(hr_addr), .hr_wdata(hr_wdata), .hr_rdata(hr_rdata),
		.hr_rvalid(hr_rvalid), .current_variant(cv), .group0_range(g0), .group1_range(g1),
		.adc_sample(adc), .rb_chan(rb_chan), .rb_range(rb_range), .rb_zero_coef(rb_zero),
		.rb_full_scale_coef(rb_full_scale), .cal_unlocked(unl), .cal_update(upd),
		.cal_span(spn),
		.cal_chan(cch), .cal_range(crg), .zero_endpoint_signal(zref),
		.full_scale_endpoint_signal(fref));

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Distinct sample per channel, salted per phase
	always @(posedge core_clk) begin
		for (int i = 0; i < 6; i++) adc[16*i +: 16] <= {4'hC, salt, 4'(i)};
	end

	// Hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	function automatic logic [15:0] smp(input logic [2:0] ch);
		return {4'hC, salt, 1'b0, ch};
	endfunction

	// Positive range limit in microvolts
	function automatic logic [31:0] vref(input logic [2:0] r);
		logic [31:0] t [8] = '{32'h0098_9680, 32'h004C_4B40, 32'h0026_25A0, 32'h0013_12D0,
			32'h0009_8968, 32'h0004_C4B4, 32'h0002_625A, 32'h0001_3132};
		return t[r];
	endfunction

	// Current endpoints in nanoamps
	function automatic logic [31:0] cref(input logic [2:0] r, input logic full_scale);
		if (r == 3'h2) return full_scale ? 32'h00AA_70D0 : 32'h000F_4240;
		if (r == 3'h3) return full_scale ? 32'h000F_4240 : 32'h0003_D090;
		return full_scale ? 32'h0131_2D00 : 32'h000F_4240;
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [15:0] a, input logic [15:0] v);
		i_ica_client_model.wr(a, v);
		// Pulses stand from the taking edge on; sampled 1 ns after it
		#1;
	endtask

	task automatic cmd_ok(input logic [15:0] a, input logic [2:0] ch, input logic sp,
		input logic [2:0] rng, input logic [31:0] z, input logic [31:0] f);
		repeat (SETTLE_CYCLES) @(posedge core_clk);
		cmd(a, 16'h0001 << ch);
		cmp(32'(upd), 32'h1);
		cmp(32'(cch), 32'(ch));
		cmp(32'(spn), 32'(sp));
		cmp(32'(crg), 32'(rng));
		cmp(zref, z);
		cmp(fref, f);
	endtask

	task automatic rbchk(input logic [2:0] ch, input logic [2:0] r, input logic [15:0] z,
		input logic [15:0] f);
		@(posedge core_clk);
		rb_chan <= ch;
		rb_range <= r;
		repeat (2) @(posedge core_clk);
		#1;
		cmp(32'(rb_zero), 32'(z));
		cmp(32'(rb_full_scale), 32'(f));
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
		i_ica_client_model.rd(a);
		// Read valid stands only one cycle
		#1;
		cmp(32'(hr_rvalid), 32'h1);
		cmp(32'(hr_rdata), 32'(exp));
	endtask

	task automatic wrap_up();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		nrst = 1'b0;
		cv = 1'b0;
		g0 = 3'h0;
		g1 = 3'h0;
		rb_chan = 3'h0;
		rb_range = 3'h0;
		salt = 8'h3C;
		ce = 1'b1;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		#1;
		cmp(32'(unl), 32'h0);
		rbchk(3'h4, 3'h2, 16'h0000, 16'hFFFF);
		rdchk(ica_pkg::ICA_REG_UNLOCK, 16'h0000);
		cmd(ica_pkg::ICA_REG_ZERO, 16'h0001);
		cmp(32'(upd), 32'h0);
		rbchk(3'h0, 3'h0, 16'h0000, 16'hFFFF);
		$display("test locked done");
		cmd(ica_pkg::ICA_REG_UNLOCK, ica_pkg::ICA_KEY);
		cmp(32'(unl), 32'h1);
		rdchk(ica_pkg::ICA_REG_UNLOCK, ica_pkg::ICA_KEY);
		// Range chosen first, zero before span
		for (int r = 0; r < 8; r++) begin
			g0 <= 3'(r);
			g1 <= 3'(7 - r);
			cmd_ok(ica_pkg::ICA_REG_ZERO, 3'(r % 3), 1'b0, 3'(r), -vref(3'(r)), vref(3'(r)));
			cmd_ok(ica_pkg::ICA_REG_SPAN, 3'(3 + r % 3), 1'b1, 3'(7 - r), -vref(3'(7 - r)),
				vref(3'(7 - r)));
			rbchk(3'(r % 3), 3'(r), smp(3'(r % 3)), 16'hFFFF);
			rbchk(3'(3 + r % 3), 3'(7 - r), 16'h0000, smp(3'(3 + r % 3)));
		end
		cmd_ok(ica_pkg::ICA_REG_ZERO, 3'h5, 1'b0, 3'h0, -vref(3'h0), vref(3'h0));
		cmd_ok(ica_pkg::ICA_REG_SPAN, 3'h0, 1'b1, 3'h7, -vref(3'h7), vref(3'h7));
		rbchk(3'h5, 3'h0, smp(3'h5), 16'hFFFF);
		$display("test voltage done");
		for (int i = 0; i < 5; i++) begin
			cmd(i < 2 ? ica_pkg::ICA_REG_ZERO : ica_pkg::ICA_REG_SPAN, bad[i]);
			cmp(32'(upd), 32'h0);
		end
		rbchk(3'h0, 3'h0, smp(3'h0), 16'hFFFF);
		$display("test bad commands done");
		cv <= 1'b1;
		salt <= 8'h5A;
		for (int r = 0; r < 4; r++) begin
			g0 <= 3'(r);
			cmd_ok(ica_pkg::ICA_REG_ZERO, 3'(r % 3), 1'b0, r == 1 ? 3'h0 : 3'(r), cref(3'(r), 1'b0),
				cref(3'(r), 1'b1));
			rbchk(3'(r % 3), 3'(r), smp(3'(r % 3)), 16'hFFFF);
		end
		rbchk(3'h1, 3'h0, smp(3'h1), 16'hFFFF);
		$display("test current done");
		// Write with ce low must not be taken
		@(posedge core_clk);
		ce <= 1'b0;
		cmd(ica_pkg::ICA_REG_UNLOCK, ica_pkg::ICA_RELOCK);
		cmp(32'(unl), 32'h1);
		ce <= 1'b1;
		cmd(ica_pkg::ICA_REG_UNLOCK, ica_pkg::ICA_RELOCK);
		cmp(32'(unl), 32'h0);
		cmd(ica_pkg::ICA_REG_SPAN, 16'h0001);
		cmp(32'(upd), 32'h0);
		rdchk(ica_pkg::ICA_REG_ZERO, 16'h0000);
		rdchk(16'h0030, 16'h0000);
		$display("test relock done");
		wrap_up();
	end
endmodule

`default_nettype wire
